// ---- verilog/spf_defines.svh ----
// constants for the supply pulse fuse programmer
// Notes on behaviour
// [R1] supply pin levels low, mid and high are decoded into commands
// [R2] try mode holds several tentative codes at once until supply cycling
// [R3] blow mode sets one parameter, then fuses it permanently
// [R4] a blown lock fuse blocks all later programming
// [R5] mid pulse count forms the key, binary, lsb is key 1
// [R6] field code is binary, code 1 is bit 0
// [R7] selected parameter follows the code while addressing, not yet permanent
// [R8] a blown fuse bit stays set and cannot be cleared
// [R9] sequence built so stray supply pulses rarely change stored values
// [R10] programmer holds low at least 40 us between pulses
// [R11] programmer holds selection and addressing pulses at least 40 us
// [R12] programmer holds blow pulses high at least 40 us
// [R13] mode key 1 blow, 2 try; keys 1,2,3,6 select parameters
// [R14] selection is high pulse, key mid pulses, high pulse
// [R15] code rises by one at each mid pulse fall, stops at maximum
// [R16] supply cycling returns unblown field positions to initial state
// [R17] a level change counts only after a stable qualification time
// [R18] with lock blown all pulse trains are ignored
`ifndef SPF_DEFINES_SVH
`define SPF_DEFINES_SVH
`define SPF_CLK_PERIOD_NS 100
`define SPF_T_QUAL_NS 20000
`define SPF_QUAL_CYC ((`SPF_T_QUAL_NS + `SPF_CLK_PERIOD_NS - 1) / `SPF_CLK_PERIOD_NS)
`define SPF_T_BLOW_NS 40000
`define SPF_BLOW_CYC ((`SPF_T_BLOW_NS + `SPF_CLK_PERIOD_NS - 1) / `SPF_CLK_PERIOD_NS)
`define SPF_KEY_BLOW 3'h1
`define SPF_KEY_TRY 3'h2
`define SPF_KEY_SENS 3'h1
`define SPF_KEY_QDC 3'h2
`define SPF_KEY_PWM 3'h3
`define SPF_KEY_LOCK 3'h6
`define SPF_KEY_MAX 3'h7
`define SPF_SENS_LSB 0
`define SPF_QDC_LSB 8
`define SPF_PWM_LSB 16
`define SPF_LOCK_BIT 24
`define SPF_CODE_W 8
`define SPF_CODE_MAX 8'hff
`define SPF_LOCK_MAX 8'h01
`define SPF_ADDR_STATUS 8'h00
`define SPF_ADDR_CODES 8'h04
`define SPF_ADDR_FUSE 8'h08
`define SPF_ADDR_CTRL 8'h0c
`define SPF_CTRL_RST 1'b1
`endif

// ---- verilog/spf_pkg.sv ----
// types for the supply pulse fuse programmer
package spf_pkg;
  typedef logic [9:0] spf_cnt_type;
  typedef logic [7:0] spf_code_type;
  typedef logic [24:0] spf_fuse_type;
  typedef enum logic [1:0] {LVL_LOW = 2'b00, LVL_MID = 2'b01, LVL_HIGH = 2'b10} spf_lvl_type;
  typedef enum logic [2:0] {
    ST_WAIT  = 3'b000,
    ST_MODE  = 3'b001,
    ST_PARAM = 3'b010,
    ST_ADDR  = 3'b011,
    ST_DONE  = 3'b100
  } spf_state_type;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } spf_apb_req_type;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } spf_apb_rsp_type;
  typedef struct packed {
    logic       lock;
    logic [7:0] pwm;
    logic [7:0] qdc;
    logic [7:0] sens;
  } spf_param_type;
endpackage

// ---- verilog/spf_programmer.sv ----
// supply pulse decoder, programming sequencer, fuse shadow, apb slave
`timescale 1ns/1ps
`include "spf_defines.svh"
module spf_programmer (
  input  wire logic                     core_clk,
  input  wire logic                     arst_n,
  input  wire logic [1:0]               supply_lvl,
  input  wire spf_pkg::spf_fuse_type    fuse_sense,
  input  wire spf_pkg::spf_apb_req_type apb_req,
  output spf_pkg::spf_apb_rsp_type      apb_rsp,
  output spf_pkg::spf_param_type        params,
  output logic                          fuse_blow,
  output spf_pkg::spf_fuse_type         fuse_blow_mask
);
  import spf_pkg::*;
  localparam spf_cnt_type QUAL_CYC = spf_cnt_type'(`SPF_QUAL_CYC);
  localparam spf_cnt_type BLOW_CYC = spf_cnt_type'(`SPF_BLOW_CYC);
  function automatic spf_lvl_type lvl_of(input logic [1:0] raw);
    // 2'b11 cannot occur from ordered comparators; treat as high
    if (raw[1]) begin
      return LVL_HIGH;
    end
    return raw[0] ? LVL_MID : LVL_LOW;
  endfunction
  function automatic logic [2:0] key_inc(input logic [2:0] k);
    return (k == `SPF_KEY_MAX) ? k : k + 3'h1;
  endfunction
  function automatic spf_code_type code_max(input logic [2:0] sel);
    return (sel == `SPF_KEY_LOCK) ? `SPF_LOCK_MAX : `SPF_CODE_MAX;
  endfunction
  function automatic spf_fuse_type place(input logic [2:0] sel, input spf_code_type c);
    spf_fuse_type f;
    f = '0;
    if (sel == `SPF_KEY_SENS) begin
      f[`SPF_SENS_LSB +: `SPF_CODE_W] = c;
    end else if (sel == `SPF_KEY_QDC) begin
      f[`SPF_QDC_LSB +: `SPF_CODE_W] = c;
    end else if (sel == `SPF_KEY_PWM) begin
      f[`SPF_PWM_LSB +: `SPF_CODE_W] = c;
    end else if (sel == `SPF_KEY_LOCK) begin
      f[`SPF_LOCK_BIT] = c[0];
    end
    return f;
  endfunction
  // reset release
  logic [1:0] rst_sync_q;
  logic       rst_n;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];
  // level decoder
  logic [1:0]  s1_q, s2_q, s3_q;
  spf_lvl_type lvl_q, lvl_d, cand;
  spf_lvl_type peak_q, peak_d;
  spf_cnt_type qcnt_q, qcnt_d;
  spf_cnt_type hicnt_q, hicnt_d;
  logic        ev_mid_q, ev_mid_d;
  logic        ev_high_q, ev_high_d;
  logic        ev_long_q, ev_long_d;
  always_comb begin
    cand = lvl_of(s3_q);
    lvl_d = lvl_q;
    qcnt_d = '0;
    // glitches shorter than the qualification time never reach lvl_q
    if (s2_q == s3_q && cand != lvl_q) begin // [R17]
      qcnt_d = qcnt_q + 10'h001;
      if (qcnt_q == QUAL_CYC - 10'h001) begin
        lvl_d = cand;
        qcnt_d = '0;
      end
    end
    // a pulse is classified by its peak, so the ramp through mid on the
    // way to high is not taken for a mid pulse
    peak_d = peak_q;
    hicnt_d = hicnt_q;
    ev_mid_d = 1'b0;
    ev_high_d = 1'b0;
    ev_long_d = 1'b0;
    if (lvl_q == LVL_LOW) begin
      peak_d = LVL_LOW;
      hicnt_d = '0;
    end else begin
      if (lvl_q == LVL_HIGH) begin
        peak_d = LVL_HIGH;
        if (hicnt_q != BLOW_CYC) begin
          hicnt_d = hicnt_q + 10'h001;
        end
      end else if (peak_q == LVL_LOW) begin
        peak_d = LVL_MID;
      end
      if (lvl_d == LVL_LOW) begin // [R1]
        ev_mid_d = (peak_d == LVL_MID);
        ev_high_d = (peak_d == LVL_HIGH);
        ev_long_d = (peak_d == LVL_HIGH) && (hicnt_d == BLOW_CYC); // [R12]
      end
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 2'b00;
      s2_q <= 2'b00;
      s3_q <= 2'b00;
      lvl_q <= LVL_LOW;
      peak_q <= LVL_LOW;
      qcnt_q <= '0;
      hicnt_q <= '0;
      ev_mid_q <= 1'b0;
      ev_high_q <= 1'b0;
      ev_long_q <= 1'b0;
    end else begin
      s1_q <= supply_lvl;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
      peak_q <= peak_d;
      qcnt_q <= qcnt_d;
      hicnt_q <= hicnt_d;
      ev_mid_q <= ev_mid_d;
      ev_high_q <= ev_high_d;
      ev_long_q <= ev_long_d;
    end
  end
  // programming sequencer
  spf_state_type state_q, state_d;
  logic          mode_q, mode_d;
  logic [2:0]    key_q, key_d;
  logic [2:0]    sel_q, sel_d;
  spf_code_type  code_q, code_d;
  spf_fuse_type  tval_q, tval_d;
  spf_fuse_type  fuse_q, fuse_d;
  spf_fuse_type  bmask_q, bmask_d;
  logic          fuse_ld_q;
  logic          blow_q, blow_d;
  spf_param_type par_q;
  logic          ctrl_en_q, ctrl_en_d;
  logic          locked, accept;
  assign locked = fuse_q[`SPF_LOCK_BIT];
  assign accept = ctrl_en_q && !locked && fuse_ld_q;
  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    key_d = key_q;
    sel_d = sel_q;
    code_d = code_q;
    tval_d = tval_q;
    fuse_d = fuse_q;
    bmask_d = bmask_q;
    blow_d = 1'b0;
    if (!fuse_ld_q) begin
      fuse_d = fuse_sense;
    end else if (locked) begin
      state_d = ST_WAIT; // [R18]
    end else if (accept && (ev_mid_q || ev_high_q)) begin
      unique case (state_q)
        ST_WAIT: begin
          if (ev_high_q) begin // [R14]
            state_d = ST_MODE;
            key_d = '0;
          end
        end
        ST_MODE: begin
          if (ev_mid_q) begin
            key_d = key_inc(key_q); // [R5]
          end else if (key_q == `SPF_KEY_BLOW || key_q == `SPF_KEY_TRY) begin // [R13]
            state_d = ST_PARAM;
            mode_d = (key_q == `SPF_KEY_BLOW);
            key_d = '0;
          end else begin
            state_d = ST_WAIT; // [R9]
          end
        end
        ST_PARAM: begin
          if (ev_mid_q) begin
            key_d = key_inc(key_q); // [R5]
          end else if (key_q == `SPF_KEY_SENS || key_q == `SPF_KEY_QDC ||
                       key_q == `SPF_KEY_PWM || key_q == `SPF_KEY_LOCK) begin // [R13]
            state_d = ST_ADDR;
            sel_d = key_q;
            code_d = '0;
            tval_d = tval_q & ~place(key_q, code_max(key_q));
          end else begin
            state_d = ST_WAIT; // [R9]
          end
        end
        ST_ADDR: begin
          if (ev_mid_q) begin
            if (code_q != code_max(sel_q)) begin
              code_d = code_q + 8'h01; // [R15]
            end
            // only the selected field moves; other try values stay
            tval_d = (tval_q & ~place(sel_q, code_max(sel_q))) | place(sel_q, code_d); // [R6] [R7] [R2]
          end else if (!mode_q) begin
            state_d = ST_PARAM;
            key_d = '0;
          end else if (ev_long_q) begin
            // short high pulses in blow mode do nothing
            bmask_d = place(sel_q, code_q); // [R3]
            fuse_d = fuse_q | bmask_d; // [R8] [R4]
            blow_d = |bmask_d;
            state_d = ST_DONE;
          end
        end
        // one field per supply cycle: the fuse supply cannot feed more
        ST_DONE: begin
          state_d = ST_DONE;
        end
        default: begin
          state_d = ST_WAIT;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_WAIT;
      mode_q <= 1'b0;
      key_q <= '0;
      sel_q <= '0;
      code_q <= '0;
      tval_q <= '0; // [R16]
      fuse_q <= '0;
      fuse_ld_q <= 1'b0;
      bmask_q <= '0;
      blow_q <= 1'b0;
      par_q <= '0;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      key_q <= key_d;
      sel_q <= sel_d;
      code_q <= code_d;
      tval_q <= tval_d;
      fuse_q <= fuse_d;
      fuse_ld_q <= 1'b1;
      bmask_q <= bmask_d;
      blow_q <= blow_d;
      par_q <= spf_param_type'(fuse_q | tval_q); // [R7]
    end
  end
  // apb slave, one wait state per access
  spf_apb_rsp_type rsp_q, rsp_d;
  logic [31:0]     rd;
  logic            hit;
  always_comb begin
    rd = '0;
    hit = 1'b1;
    case (apb_req.paddr)
      `SPF_ADDR_STATUS: rd[5:0] = {fuse_ld_q, locked, mode_q, state_q};
      `SPF_ADDR_CODES:  rd[24:0] = par_q;
      `SPF_ADDR_FUSE:   rd[24:0] = fuse_q;
      `SPF_ADDR_CTRL:   rd[0] = ctrl_en_q;
      default:          hit = 1'b0;
    endcase
    rsp_d = '0;
    ctrl_en_d = ctrl_en_q;
    if (apb_req.psel && apb_req.penable && !rsp_q.pready) begin
      rsp_d.pready = 1'b1;
      rsp_d.pslverr = !hit;
      rsp_d.prdata = apb_req.pwrite ? 32'h0000_0000 : rd;
    end
    if (apb_req.psel && apb_req.penable && rsp_q.pready && apb_req.pwrite &&
        apb_req.paddr == `SPF_ADDR_CTRL) begin
      ctrl_en_d = apb_req.pwdata[0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_q <= '0;
      ctrl_en_q <= `SPF_CTRL_RST;
    end else begin
      rsp_q <= rsp_d;
      ctrl_en_q <= ctrl_en_d;
    end
  end

  assign apb_rsp = rsp_q;
  assign params = par_q;
  assign fuse_blow = blow_q;
  assign fuse_blow_mask = bmask_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_qual_time: // [R17]
    assert property ($changed(lvl_q) |-> $past(qcnt_q) == QUAL_CYC - 10'h001)
    else $error("level taken before qualification");
  a_high_event: // [R1]
    assert property (ev_high_q |-> lvl_q == LVL_LOW && $past(lvl_q) != LVL_LOW)
    else $error("high event without pulse end");
  a_mode_try: // [R13]
    assert property ((accept && state_q == ST_MODE && ev_high_q && key_q == `SPF_KEY_TRY)
                     |=> state_q == ST_PARAM && !mode_q)
    else $error("try key not taken");
  a_key_count: // [R5]
    assert property ((accept && state_q == ST_PARAM && ev_mid_q && key_q != `SPF_KEY_MAX)
                     |=> key_q == $past(key_q) + 3'h1)
    else $error("key not counted");
  a_code_step: // [R15]
    assert property ((accept && state_q == ST_ADDR && ev_mid_q && code_q != code_max(sel_q))
                     |=> code_q == $past(code_q) + 8'h01)
    else $error("code did not step");
  a_code_field: // [R6]
    assert property ((state_q == ST_ADDR && sel_q == `SPF_KEY_QDC)
                     |-> tval_q[`SPF_QDC_LSB +: `SPF_CODE_W] == code_q)
    else $error("field differs from code");
  a_param_follow: // [R7]
    assert property ((state_q == ST_ADDR && sel_q == `SPF_KEY_SENS)
                     |=> par_q.sens == ($past(code_q) | $past(fuse_q[7:0])))
    else $error("parameter not following code");
  a_try_keep: // [R2]
    assert property ((state_q == ST_ADDR && ev_mid_q && sel_q == `SPF_KEY_SENS)
                     |=> $stable(tval_q[`SPF_QDC_LSB +: `SPF_CODE_W]))
    else $error("other try value disturbed");
  a_fuse_sticky: // [R8]
    assert property (fuse_ld_q && $past(fuse_ld_q) |-> (fuse_q & $past(fuse_q)) == $past(fuse_q))
    else $error("blown fuse cleared");
  a_blow_cause: // [R3]
    assert property (blow_q |-> $past(ev_long_q) && $past(mode_q) && $past(state_q) == ST_ADDR)
    else $error("blow without long pulse in blow mode");
  a_short_pulse: // [R9]
    assert property ((ev_high_q && !ev_long_q) |=> !blow_q)
    else $error("short pulse blew a fuse");
  a_locked_idle: // [R18]
    assert property (locked |=> state_q == ST_WAIT && !blow_q)
    else $error("locked device still programming");
  a_lock_blocks: // [R4]
    assert property (locked && $past(locked) |-> $stable(tval_q))
    else $error("locked device changed a code");
endmodule

// ---- sim/spf_supply_model.sv ----
// programmer side model: three level supply pulses and the fuse array
`timescale 1ns/1ps
module spf_supply_model (
  input  wire logic                  core_clk,
  input  wire logic                  fuse_blow,
  input  wire spf_pkg::spf_fuse_type fuse_blow_mask,
  output logic [1:0]                 supply_lvl,
  output spf_pkg::spf_fuse_type      fuse_sense
);
  import spf_pkg::*;
  initial begin
    supply_lvl = 2'h0;
    fuse_sense = '0;
  end
  // fuses only gain bits, they survive power cycles
  always @(posedge core_clk) begin
    if (fuse_blow === 1'b1) begin
      fuse_sense <= fuse_sense | fuse_blow_mask;
    end
  end
  // one pulse, then the separating low level
  task automatic pulse(input logic [1:0] lvl, input int act, input int gap);
    @(posedge core_clk);
    supply_lvl <= lvl;
    repeat (act) @(posedge core_clk);
    supply_lvl <= 2'h0;
    repeat (gap) @(posedge core_clk);
  endtask
endmodule

// ---- sim/tb.sv ----
// self-checking bench for the supply pulse fuse programmer
`timescale 1ns/1ps
module tb;
  import spf_pkg::*;
  typedef struct {logic blow; logic care; logic [32:0] v;} spf_note_type;
  localparam int ACT  = 420;
  localparam int BLOW = 720;
  logic            core_clk;
  logic            arst_n;
  logic [1:0]      supply_lvl;
  spf_fuse_type    fuse_sense;
  spf_apb_req_type apb_req;
  spf_apb_rsp_type apb_rsp;
  spf_param_type   params;
  logic            fuse_blow;
  spf_fuse_type    fuse_blow_mask;
  spf_note_type    notes[$];
  spf_note_type    nt;
  logic [32:0]     seen;
  int              fails;
  int              checked;
  int              n;
  int              m;

  spf_programmer spf_programmer_inst (.core_clk(core_clk), .arst_n(arst_n), .supply_lvl(supply_lvl),
    .fuse_sense(fuse_sense), .apb_req(apb_req), .apb_rsp(apb_rsp), .params(params), .fuse_blow(fuse_blow),
    .fuse_blow_mask(fuse_blow_mask));
  spf_supply_model spf_supply_model_inst (.core_clk(core_clk), .fuse_blow(fuse_blow),
    .fuse_blow_mask(fuse_blow_mask), .supply_lvl(supply_lvl), .fuse_sense(fuse_sense));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic summarize;
    $display("checks %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // results taken at the edge that samples them, before the design updates
  always @(posedge core_clk) begin
    if (apb_rsp.pready === 1'b1 || fuse_blow === 1'b1) begin
      seen = (fuse_blow === 1'b1) ? {8'h0, fuse_blow_mask} : {apb_rsp.pslverr, apb_rsp.prdata};
      checked++;
      if (notes.size() == 0) begin
        fails++;
        $display("ERROR unexpected result expected none seen %h", seen);
      end else begin
        nt = notes.pop_front();
        if (nt.blow !== fuse_blow || (nt.care && nt.v !== seen)) begin
          fails++;
          $display("ERROR %s expected %h seen %h", nt.blow ? "blow mask" : "read data", nt.v, seen);
        end
        // the parameter port must agree with the code word just read
        if (!nt.blow && nt.care && apb_req.paddr == 8'h04) begin
          checked++;
          if (params !== nt.v[24:0]) begin
            fails++;
            $display("ERROR params expected %h seen %h", nt.v[24:0], params);
          end
        end
      end
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (apb_rsp.pready !== 1'b1 && k < 20);
    if (apb_rsp.pready !== 1'b1) begin
      fails++;
      summarize();
    end
    apb_req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
    notes.push_back('{1'b0, 1'b1, {err, e}});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    notes.push_back('{1'b0, 1'b0, 33'h0});
    apb(1'b1, a, d);
  endtask

  // pulse widths jitter above the minimum
  task automatic mids(input int cnt);
    repeat (cnt) spf_supply_model_inst.pulse(2'h1, ACT + int'($urandom % 40), ACT);
  endtask

  task automatic high(input int act);
    spf_supply_model_inst.pulse(2'h2, act, ACT);
  endtask

  task automatic sel(input int mode, input int par, input int code);
    high(ACT);
    mids(mode);
    high(ACT);
    mids(par);
    high(ACT);
    mids(code);
  endtask

  task automatic power_cycle;
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask

  initial begin
    repeat (95000) @(posedge core_clk);
    fails++;
    summarize();
  end

  initial begin
    arst_n = 1'b0;
    apb_req = '0;
    fails = 0;
    checked = 0;
    void'($urandom(84));
    power_cycle();
    rd(8'h00, 32'h20, 1'b0);
    rd(8'h0c, 32'h1, 1'b0);
    wr(8'h00, 32'hff);
    rd(8'h00, 32'h20, 1'b0);
    rd(8'h10, 32'h0, 1'b1);
    rd(8'h08, 32'h0, 1'b0);
    // unknown mode key falls back to waiting
    high(ACT);
    mids(3);
    high(ACT);
    rd(8'h00, 32'h20, 1'b0);
    n = 1 + int'($urandom % 5);
    m = 1 + int'($urandom % 5);
    sel(2, 2, n);
    spf_supply_model_inst.pulse(2'h1, 100, ACT);
    rd(8'h04, 32'(n) << 8, 1'b0);
    rd(8'h00, 32'h23, 1'b0);
    high(ACT);
    mids(3);
    high(ACT);
    mids(m);
    rd(8'h04, (32'(n) << 8) | (32'(m) << 16), 1'b0);
    power_cycle();
    rd(8'h04, 32'h0, 1'b0);
    // programming switched off leaves the sequencer idle
    wr(8'h0c, 32'h0);
    rd(8'h0c, 32'h0, 1'b0);
    sel(2, 1, 2);
    rd(8'h00, 32'h20, 1'b0);
    wr(8'h0c, 32'h1);
    sel(1, 1, 4);
    rd(8'h04, 32'h4, 1'b0);
    // a short high in blow mode must leave the fuses alone
    high(250);
    rd(8'h00, 32'h2b, 1'b0);
    notes.push_back('{1'b1, 1'b1, 33'h4});
    high(BLOW);
    rd(8'h00, 32'h2c, 1'b0);
    power_cycle();
    rd(8'h08, 32'h4, 1'b0);
    rd(8'h04, 32'h4, 1'b0);
    sel(1, 6, 2);
    rd(8'h04, 32'h1000004, 1'b0);
    notes.push_back('{1'b1, 1'b1, 33'h1000000});
    high(BLOW);
    power_cycle();
    rd(8'h00, 32'h30, 1'b0);
    sel(2, 2, 3);
    rd(8'h04, 32'h1000004, 1'b0);
    rd(8'h00, 32'h30, 1'b0);
    repeat (5) @(posedge core_clk);
    summarize();
  end
endmodule
